// >>> rtl/adc_pins.sv
// Pin logic of the converter host interface with an AXI4-Lite register slave
//
// Summary of operation
// - Low polarity: marker high during valid data
// - High polarity: marker low during valid data
// - Modes 0-2 parallel bits, mode 3 serial
// - Slave read cut by conversion: drop, pulse flag
// - Select input picks pins or config port
// - Config clock edge chosen by clock invert
// - Config port acts only while enabled
// - Busy high from start until result latched
// - Parallel modes: range pin picks 10 V
// - Serial: pin or config port picks range
// - Output bus driven only with select, strobe low, except serial marker, error and master clock pins
// - Clock source high is slave, low master
// - Slave updates rising, or falling when inverted
`timescale 1ns/100ps

module adc_pins (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt
    output logic irq,
    // Control pins from the host
    input wire logic [1:0] mode,
    input wire logic conv_start_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wide_range_select,
    input wire logic frame_marker_polarity,
    input wire logic serial_clock_invert,
    input wire logic clock_source_select,
    // Shared 18-bit data pins
    input wire logic [17:0] data_pin_in,
    output logic [17:0] data_pin_out,
    output logic [17:0] data_pin_oe,
    // Converter core side
    input wire logic [17:0] conv_result,
    output logic conversion_busy,
    output logic range_10v,
    output logic config_mode_bit
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [7:0] CONV_LAST = 8'(adc_pins_pkg::CONV_CYC - 1);
    localparam logic [2:0] HALF_LAST = 3'(adc_pins_pkg::SCLK_HALF_CYC - 1);
    localparam logic [4:0] BIT_LAST = 5'(adc_pins_pkg::RES_BITS - 1);
    localparam logic [1:0] CFG_FULL = 2'(adc_pins_pkg::CFG_WIDTH);

    adc_pins_pkg::state_t r;
    adc_pins_pkg::state_t n;
    adc_pins_pkg::async_in_t async_now;

    logic serial;
    logic slave;
    logic master;
    logic bus_en;
    logic pop;
    logic upd_edge;
    logic cfg_edge;
    logic cfg_close;
    logic start_req;
    logic conv_done;
    logic aw_fire;
    logic w_fire;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [adc_pins_pkg::IRQ_W-1:0] irq_set;
    logic [adc_pins_pkg::IRQ_W-1:0] irq_clr;
    logic m_toggle;

    // Gather the outside-domain inputs; pins 14 to 17 and 11 carry serial-mode inputs
    assign async_now = '{
        conv_start_n: conv_start_n,
        rd_n: rd_n,
        cs_n: cs_n,
        wide_range_select: wide_range_select,
        frame_marker_polarity: frame_marker_polarity,
        serial_clock_invert: serial_clock_invert,
        clock_source_select: clock_source_select,
        mode: mode,
        config_port_enable: data_pin_in[17],
        config_port_clock: data_pin_in[16],
        config_port_data_in: data_pin_in[15],
        pin_or_port_select: data_pin_in[14],
        sclk: data_pin_in[adc_pins_pkg::PIN_SCLK]
    };

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        n = r;

        // Three-stage sampling; a bit moves only once stages two and three agree
        n.s1 = async_now;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.f = adc_pins_pkg::async_in_t'((~(r.s2 ^ r.s3) & r.s2) | ((r.s2 ^ r.s3) & r.f));

        // Mode decode
        serial = (r.f.mode == adc_pins_pkg::SERIAL_MODE);
        slave = serial & r.f.clock_source_select;
        master = serial & ~r.f.clock_source_select;
        bus_en = ~r.f.cs_n & ~r.f.rd_n;
        pop = r.f.pin_or_port_select;

        // Serial clock edge that moves the next bit out
        if (r.f.serial_clock_invert) begin
            upd_edge = ~n.f.sclk & r.f.sclk;
        end else begin
            upd_edge = n.f.sclk & ~r.f.sclk;
        end

        // Config clock edge follows the same invert input
        if (r.f.serial_clock_invert) begin
            cfg_edge = ~n.f.config_port_clock & r.f.config_port_clock;
        end else begin
            cfg_edge = n.f.config_port_clock & ~r.f.config_port_clock;
        end
        cfg_close = ~n.f.config_port_enable & r.f.config_port_enable;

        // Master clock divider; the falling half moves data
        m_toggle = 1'b0;
        if (master && r.rd_st == adc_pins_pkg::RD_SHIFT) begin
            if (r.div_cnt == HALF_LAST) begin
                n.div_cnt = 3'h0;
                n.sclk = ~r.sclk;
                m_toggle = 1'b1;
            end else begin
                n.div_cnt = r.div_cnt + 3'h1;
            end
        end else begin
            n.div_cnt = 3'h0;
            n.sclk = 1'b0;
        end

        // AXI write channels, taken in either order
        awready = ~r.aw_hold & ~r.bvalid;
        wready = ~r.w_hold & ~r.bvalid;
        aw_fire = awvalid & awready;
        w_fire = wvalid & wready;
        if (aw_fire) begin
            n.aw_hold = 1'b1;
            n.aw_addr = awaddr;
        end
        if (w_fire) begin
            n.w_hold = 1'b1;
            n.w_data = wdata;
            n.w_strb = wstrb;
        end
        wr_go = (r.aw_hold | aw_fire) & (r.w_hold | w_fire);
        wr_addr = r.aw_hold ? r.aw_addr : awaddr;
        wr_data = r.w_hold ? r.w_data : wdata;
        wr_strb = r.w_hold ? r.w_strb : wstrb;

        // Register write effects
        irq_clr = '0;
        start_req = ~n.f.conv_start_n & r.f.conv_start_n;
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.aw_hold = 1'b0;
            n.w_hold = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = adc_pins_pkg::RESP_OKAY;
            unique case (wr_addr)
                adc_pins_pkg::CTRL_OFS: begin
                    start_req = start_req | (wr_strb[0] & wr_data[adc_pins_pkg::CTRL_START_BIT]);
                end
                adc_pins_pkg::IRQ_STAT_OFS: begin
                    irq_clr = wr_strb[0] ? wr_data[adc_pins_pkg::IRQ_W-1:0] : '0;
                end
                adc_pins_pkg::IRQ_MASK_OFS: begin
                    if (wr_strb[0]) begin
                        n.irq_mask = wr_data[adc_pins_pkg::IRQ_W-1:0];
                    end
                end
                adc_pins_pkg::STATUS_OFS, adc_pins_pkg::RESULT_OFS, adc_pins_pkg::CFG_OFS: begin
                    // Read-only: write ignored
                end
                default: begin
                    n.bresp = adc_pins_pkg::RESP_SLVERR;
                end
            endcase
        end

        // AXI read channel
        arready = ~r.rvalid;
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            n.rvalid = 1'b1;
            n.rresp = adc_pins_pkg::RESP_OKAY;
            n.rdata = 32'h0;
            unique case (araddr)
                adc_pins_pkg::CTRL_OFS: begin
                    n.rdata = 32'h0;
                end
                adc_pins_pkg::STATUS_OFS: begin
                    n.rdata[adc_pins_pkg::ST_BUSY] = r.busy;
                    n.rdata[adc_pins_pkg::ST_AVAIL] = r.avail;
                    n.rdata[adc_pins_pkg::ST_RANGE] = r.range10;
                    n.rdata[adc_pins_pkg::ST_SERIAL] = serial;
                    n.rdata[adc_pins_pkg::ST_MASTER] = master;
                    n.rdata[adc_pins_pkg::ST_READING] = (r.rd_st == adc_pins_pkg::RD_SHIFT);
                end
                adc_pins_pkg::RESULT_OFS: begin
                    n.rdata[adc_pins_pkg::RES_BITS-1:0] = r.result;
                end
                adc_pins_pkg::CFG_OFS: begin
                    n.rdata[adc_pins_pkg::CFG_WIDTH-1:0] = r.cfg;
                end
                adc_pins_pkg::IRQ_STAT_OFS: begin
                    n.rdata[adc_pins_pkg::IRQ_W-1:0] = r.irq_st;
                end
                adc_pins_pkg::IRQ_MASK_OFS: begin
                    n.rdata[adc_pins_pkg::IRQ_W-1:0] = r.irq_mask;
                end
                default: begin
                    n.rresp = adc_pins_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Conversion timer; busy drops in the same edge the result is latched
        irq_set = '0;
        conv_done = r.busy & (r.conv_cnt == CONV_LAST);
        if (r.busy) begin
            if (conv_done) begin
                n.busy = 1'b0;
                n.result = conv_result;
                n.avail = 1'b1;
                irq_set[adc_pins_pkg::IRQ_CONV] = 1'b1;
            end else begin
                n.conv_cnt = r.conv_cnt + 8'h1;
            end
        end else if (start_req) begin
            n.busy = 1'b1;
            n.conv_cnt = 8'h0;
        end

        // Serial read sequencer
        n.flag = 1'b0;
        unique case (r.rd_st)
            adc_pins_pkg::RD_IDLE: begin
                if (master && conv_done) begin
                    // Master reads after convert, straight from the core
                    n.rd_st = adc_pins_pkg::RD_SHIFT;
                    n.sh = conv_result;
                    n.bit_cnt = 5'h0;
                    n.avail = 1'b0;
                end else if (slave && r.avail && bus_en) begin
                    n.rd_st = adc_pins_pkg::RD_SHIFT;
                    n.sh = r.result;
                    n.bit_cnt = 5'h0;
                    n.avail = conv_done; // A word landing now stays available
                end
            end
            adc_pins_pkg::RD_SHIFT: begin
                if (!serial) begin
                    n.rd_st = adc_pins_pkg::RD_IDLE;
                end else if (slave && conv_done) begin
                    // Unfinished read: the new word is lost and the flag pulses
                    n.rd_st = adc_pins_pkg::RD_IDLE;
                    n.avail = 1'b0;
                    n.flag = 1'b1;
                    irq_set[adc_pins_pkg::IRQ_RDERR] = 1'b1;
                end else if (master && conv_done) begin
                    // A fresh word restarts the master frame
                    n.sh = conv_result;
                    n.bit_cnt = 5'h0;
                    n.avail = 1'b0;
                end else if ((slave && upd_edge) || (master && m_toggle && r.sclk)) begin
                    if (r.bit_cnt == BIT_LAST) begin
                        n.rd_st = adc_pins_pkg::RD_IDLE;
                    end else begin
                        n.sh = {r.sh[adc_pins_pkg::RES_BITS-2:0], 1'b0};
                        n.bit_cnt = r.bit_cnt + 5'h1;
                    end
                end
            end
        endcase

        // Configuration port; only with the select low and the enable high
        if (serial && !pop && r.f.config_port_enable) begin
            if (cfg_edge) begin
                n.cfg_sh = {r.cfg_sh[adc_pins_pkg::CFG_WIDTH-2:0], r.f.config_port_data_in};
                if (r.cfg_cnt != CFG_FULL) begin
                    n.cfg_cnt = r.cfg_cnt + 2'h1;
                end
            end
        end
        if (cfg_close) begin
            // A short word is dropped rather than half-applied
            if (serial && !pop && r.cfg_cnt == CFG_FULL) begin
                n.cfg = r.cfg_sh;
                irq_set[adc_pins_pkg::IRQ_CFG] = 1'b1;
            end
            n.cfg_cnt = 2'h0;
        end

        // Range source: pin in parallel modes, pin or stored word in serial
        if (!serial) begin
            n.range10 = r.f.wide_range_select;
        end else if (pop) begin
            n.range10 = r.f.wide_range_select;
        end else begin
            n.range10 = r.cfg[0];
        end

        // Sticky interrupt bits; a set in the clearing cycle wins
        n.irq_st = (r.irq_st & ~irq_clr) | irq_set;

        // Pin drive, registered so the data pins come from flops
        n.pin_out = '0;
        n.pin_oe = '0;
        if (!serial) begin
            n.pin_out = r.result;
            n.pin_oe = bus_en ? '1 : '0;
        end else begin
            n.pin_out[adc_pins_pkg::PIN_SER_OUT] = r.sh[adc_pins_pkg::RES_BITS-1];
            n.pin_oe[adc_pins_pkg::PIN_SER_OUT] = bus_en;
            n.pin_out[adc_pins_pkg::PIN_SCLK] = r.sclk;
            n.pin_oe[adc_pins_pkg::PIN_SCLK] = master;
            // Marker is active while shifting, inverted by the polarity input
            n.pin_out[adc_pins_pkg::PIN_MARK] =
                (r.rd_st == adc_pins_pkg::RD_SHIFT) ^ r.f.frame_marker_polarity;
            n.pin_oe[adc_pins_pkg::PIN_MARK] = 1'b1;
            n.pin_out[adc_pins_pkg::PIN_RDERR] = r.flag;
            n.pin_oe[adc_pins_pkg::PIN_RDERR] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '{
                s1: adc_pins_pkg::ASYNC_RST,
                s2: adc_pins_pkg::ASYNC_RST,
                s3: adc_pins_pkg::ASYNC_RST,
                f: adc_pins_pkg::ASYNC_RST,
                rd_st: adc_pins_pkg::RD_IDLE,
                cfg: adc_pins_pkg::CFG_RST,
                irq_mask: adc_pins_pkg::IRQ_MASK_RST,
                default: '0
            };
        end else begin
            r <= n;
        end
    end

    // Outputs
    assign bresp = r.bresp;
    assign bvalid = r.bvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;
    assign rvalid = r.rvalid;
    assign irq = |(r.irq_st & r.irq_mask);
    assign data_pin_out = r.pin_out;
    assign data_pin_oe = r.pin_oe;
    assign conversion_busy = r.busy;
    assign range_10v = r.range10;
    assign config_mode_bit = r.cfg[1];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_marker_high: assert property (
        (r.f.mode == adc_pins_pkg::SERIAL_MODE && !r.f.frame_marker_polarity && r.rd_st == adc_pins_pkg::RD_SHIFT)
        |=> data_pin_out[adc_pins_pkg::PIN_MARK] && data_pin_oe[adc_pins_pkg::PIN_MARK])
        else $error("marker not high during frame");

    a_marker_low: assert property (
        (r.f.mode == adc_pins_pkg::SERIAL_MODE && r.f.frame_marker_polarity && r.rd_st == adc_pins_pkg::RD_SHIFT)
        |=> !data_pin_out[adc_pins_pkg::PIN_MARK])
        else $error("marker not low during frame");

    a_parallel_bits: assert property (
        (r.f.mode != adc_pins_pkg::SERIAL_MODE && !r.f.cs_n && !r.f.rd_n)
        |=> data_pin_oe[17:13] == 5'h1f && data_pin_out[17:13] == $past(r.result[17:13]))
        else $error("parallel bits 13-17 wrong");

    a_rderr_pulse: assert property (
        (slave && r.rd_st == adc_pins_pkg::RD_SHIFT && conv_done)
        |=> r.flag && !r.avail ##1 !r.flag && data_pin_out[adc_pins_pkg::PIN_RDERR])
        else $error("incomplete read not flagged");

    a_cfg_blocked: assert property (
        (serial && pop) |=> $stable(r.cfg))
        else $error("config changed with select high");

    a_busy_latch: assert property (
        $fell(r.busy) |-> $past(r.conv_cnt) == CONV_LAST && r.result == $past(conv_result) && r.irq_st[0])
        else $error("busy fell without result");

    a_busy_hold: assert property (
        $rose(r.busy) |-> r.busy [*8])
        else $error("busy too short");

    a_range_pin: assert property (
        (!serial || pop) |=> r.range10 == $past(r.f.wide_range_select))
        else $error("range not from pin");

    a_range_port: assert property (
        (serial && !pop) |=> r.range10 == $past(r.cfg[0]))
        else $error("range not from config port");

    a_bus_gate: assert property (
        (data_pin_oe[adc_pins_pkg::PIN_SER_OUT] || data_pin_oe[0]) |-> $past(bus_en))
        else $error("output bus driven without select and strobe");

    a_slave_shift: assert property (
        (slave && upd_edge && r.rd_st == adc_pins_pkg::RD_SHIFT && !conv_done && r.bit_cnt != BIT_LAST)
        |=> r.bit_cnt == $past(r.bit_cnt) + 5'h1 && r.sh[17] == $past(r.sh[16]))
        else $error("slave shift missed its edge");

endmodule : adc_pins

// >>> inc/adc_pins_pkg.sv
// Constants and types for the converter pin logic and its register slave
package adc_pins_pkg;

    // Clock and timing
    localparam int CLK_MHZ = 50;
    localparam int CONV_TIME_NS = 1000;
    localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SCLK_HALF_NS = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;

    // Widths and modes
    localparam int RES_BITS = 18;
    localparam int CFG_WIDTH = 2;
    localparam logic [1:0] SERIAL_MODE = 2'h3;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] RESULT_OFS = 8'h08;
    localparam logic [7:0] CFG_OFS = 8'h0c;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_AVAIL = 1;
    localparam int ST_RANGE = 2;
    localparam int ST_SERIAL = 3;
    localparam int ST_MASTER = 4;
    localparam int ST_READING = 5;
    localparam int IRQ_CONV = 0;
    localparam int IRQ_RDERR = 1;
    localparam int IRQ_CFG = 2;
    localparam int IRQ_W = 3;

    // Shared pin positions on the 18-bit data bus
    localparam int PIN_SER_OUT = 10;
    localparam int PIN_SCLK = 11;
    localparam int PIN_MARK = 12;
    localparam int PIN_RDERR = 13;

    // Reset values and bus answers
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [CFG_WIDTH-1:0] CFG_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Inputs arriving from outside the clock domain
    typedef struct packed {
        logic conv_start_n;
        logic rd_n;
        logic cs_n;
        logic wide_range_select;
        logic frame_marker_polarity;
        logic serial_clock_invert;
        logic clock_source_select;
        logic [1:0] mode;
        logic config_port_enable;
        logic config_port_clock;
        logic config_port_data_in;
        logic pin_or_port_select;
        logic sclk;
    } async_in_t;

    localparam async_in_t ASYNC_RST = '{conv_start_n: 1'b1, rd_n: 1'b1, cs_n: 1'b1, default: '0};

    typedef enum logic {RD_IDLE, RD_SHIFT} rd_state_t;

    // Whole state of the block
    typedef struct packed {
        async_in_t s1;
        async_in_t s2;
        async_in_t s3;
        async_in_t f;
        rd_state_t rd_st;
        logic busy;
        logic [7:0] conv_cnt;
        logic [RES_BITS-1:0] result;
        logic avail;
        logic [RES_BITS-1:0] sh;
        logic [4:0] bit_cnt;
        logic [2:0] div_cnt;
        logic sclk;
        logic flag;
        logic [CFG_WIDTH-1:0] cfg_sh;
        logic [1:0] cfg_cnt;
        logic [CFG_WIDTH-1:0] cfg;
        logic range10;
        logic [RES_BITS-1:0] pin_out;
        logic [RES_BITS-1:0] pin_oe;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

endpackage : adc_pins_pkg

// >>> tb/host_side.sv
// Host model: slave serial clock and configuration port drive
`timescale 1ns/100ps

module host_side (
    // Clock
    input wire logic aclk,
    // Serial data from the device
    input wire logic sdo,
    // Pins seen by the device
    output logic [17:0] pins
);
    initial pins = 18'h00000;

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Half period of 80 ns, four aclk cycles
    task automatic half();
        repeat (4) @(posedge aclk);
    endtask : half

    // Clock stays low outside frames; sample just before each update edge
    task automatic frame(input int n, input logic inv, output logic [17:0] w);
        w = 18'h00000;
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            if (!inv) w = {w[16:0], sdo};
            @(posedge aclk);
            pins[11] <= 1'b1;
            repeat (3) @(posedge aclk);
            @(negedge aclk);
            if (inv) w = {w[16:0], sdo};
            @(posedge aclk);
            pins[11] <= 1'b0;
        end
    endtask : frame

    // Enable held over the whole write, data set before each rising edge
    task automatic cfg(input logic [1:0] v);
        pins[17] <= 1'b1;
        for (int i = 1; i >= 0; i--) begin
            pins[15] <= v[i];
            half();
            pins[16] <= 1'b1;
            half();
            pins[16] <= 1'b0;
        end
        half();
        pins[17] <= 1'b0;
        pins[15] <= ~v[0]; // Released line shows no stale value
        half();
    endtask : cfg

    // Pin or port select level
    task automatic sel(input logic v);
        pins[14] <= v;
    endtask : sel
endmodule : host_side

// >>> tb/adc_pins_tb.sv
// Self-checking testbench for the converter pin logic
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t bad %h", $time, a); end end
`define WT(c) begin k = 0; while (!(c) && k < 400) begin @(negedge aclk); k++; end if (k == 400) begin err_total++; test_done(); end @(posedge aclk); end

module adc_pins_tb;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, q, rdata;
    logic [1:0] mode = 2'h0, r, bresp, rresp;
    logic conv_start_n = 1, cs_n = 1, rd_n = 1, wrs = 0, pol = 1, css = 1, inv = 0;
    logic [17:0] res = 18'h2a5c3, w, pin_in, pout, poe;
    logic awready, wready, bvalid, arready, rvalid, irq, busy, r10, cmb;
    int err_total = 0, n_tests = 0, k;
    // Rows: address, expected response; read data after reset is zero
    logic [9:0] rows [5] = '{{8'h04, 2'h0}, {8'h0c, 2'h0}, {8'h10, 2'h0}, {8'h14, 2'h0}, {8'h18, 2'h2}};

    adc_pins dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .irq(irq), .mode(mode), .conv_start_n(conv_start_n), .cs_n(cs_n),
        .rd_n(rd_n), .wide_range_select(wrs), .frame_marker_polarity(pol), .serial_clock_invert(inv),
        .clock_source_select(css), .data_pin_in(pin_in), .data_pin_out(pout), .data_pin_oe(poe),
        .conv_result(res), .conversion_busy(busy), .range_10v(r10), .config_mode_bit(cmb));
    host_side host (.aclk(aclk), .sdo(pout[10]), .pins(pin_in));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // Readies sampled at the falling edge, so no race with the rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
                        output logic [1:0] rs);
        logic ta, tw, tr, dn;
        int n;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= {3{wr}};
        {arvalid, rready} <= {2{!wr}};
        for (n = 0; n < 99; n++) begin
            @(negedge aclk);
            {ta, tw, tr} = {awready, wready, arready};
            dn = wr ? bvalid : rvalid;
            rq = rdata;
            rs = wr ? bresp : rresp;
            @(posedge aclk);
            if (dn) break;
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
        end
        // Release the answer ready, then let an edge pass before the next request
        {bready, rready} <= 2'b00;
        @(posedge aclk);
        if (n == 99) begin
            err_total++;
            test_done();
        end
    endtask : xfer

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    always #10 aclk = ~aclk;

    initial begin
        cyc(4);
        aresetn <= 1'b1;
        cyc(8);
        for (int i = 0; i < 5; i++) begin
            xfer(0, rows[i][9:2], 32'h0, q, r);
            `CHK({q, r}, {32'h0, rows[i][1:0]})
        end
        // Parallel conversion and output bus
        xfer(1, 8'h14, 32'h7, q, r);
        conv_start_n <= 1'b0;
        cyc(4);
        conv_start_n <= 1'b1;
        `WT(busy)
        `WT(!busy)
        `CHK(k, 50)
        `CHK(irq, 1'b1)
        xfer(0, 8'h08, 32'h0, q, r);
        `CHK(q[17:0], res)
        {cs_n, rd_n, wrs} <= 3'b001;
        cyc(8);
        `CHK({poe, pout, r10}, {18'h3ffff, res, 1'b1})
        rd_n <= 1'b1;
        cyc(8);
        `CHK(poe, 18'h0)
        xfer(1, 8'h10, 32'h7, q, r);
        `CHK(irq, 1'b0)
        // Serial slave frame, marker active low
        {mode, cs_n, wrs, res} <= {2'h3, 1'b1, 1'b0, 18'h1b6e9};
        cyc(8);
        xfer(1, 8'h00, 32'h1, q, r);
        `WT(!busy)
        {cs_n, rd_n} <= 2'b00;
        cyc(8);
        `CHK({pout[12], poe[10]}, 2'b01)
        host.frame(18, 1'b0, w);
        `CHK(w, res)
        cyc(8);
        `CHK(pout[12], 1'b1)
        // Conversion ends inside an open frame
        {pol, cs_n, rd_n, inv} <= 4'b0111;
        xfer(1, 8'h00, 32'h1, q, r);
        `CHK(r, 2'h0)
        `WT(!busy)
        {cs_n, rd_n} <= 2'b00;
        cyc(8);
        `CHK(pout[12], 1'b1)
        host.frame(5, 1'b1, w);
        `CHK(w[4:0], res[17:13])
        xfer(1, 8'h00, 32'h1, q, r);
        `WT(pout[13])
        xfer(0, 8'h10, 32'h0, q, r);
        `CHK(q[1], 1'b1)
        // Configuration port sets range, pin select overrides
        {cs_n, rd_n, inv} <= 3'b110;
        host.cfg(2'h3);
        cyc(8);
        xfer(0, 8'h0c, 32'h0, q, r);
        `CHK({q[1:0], r10, cmb}, 4'hf)
        host.sel(1'b1);
        cyc(8);
        `CHK(r10, 1'b0)
        host.sel(1'b0);
        css <= 1'b0;
        cyc(8);
        `CHK({r10, poe[11]}, 2'b11)
        // Master frame opens by itself once the conversion ends
        xfer(1, 8'h00, 32'h1, q, r);
        `WT(!busy)
        xfer(0, 8'h04, 32'h0, q, r);
        `CHK(q[5:0], 6'h3c)
        `CHK(pout[12], 1'b1)
        // Reset in mid-run drops drive, interrupt and stored settings
        aresetn <= 1'b0;
        cyc(2);
        `CHK({poe, irq, cmb, busy}, 21'h0)
        aresetn <= 1'b1;
        xfer(0, 8'h0c, 32'h0, q, r);
        `CHK(q, 32'h0)
        test_done();
    end
endmodule : adc_pins_tb
